//--- dv/mrie_exec_props.sv
`timescale 1ns/1ps
`default_nettype none
module mrie_exec_props (
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  input wire logic INSTR_VALID,
  input wire mrie_pkg::mrie_instr_t INSTR_WORD,
  input wire logic INSTR_READY,
  input wire logic STACK_PUSH,
  input wire mrie_pkg::mrie_pc_t STACK_PUSH_ADDR,
  input wire logic GIE_CLEAR,
  input wire mrie_pkg::mrie_pc_t PC,
  input wire mrie_pkg::mrie_data_t ACC,
  input wire logic FILE_WE,
  input wire mrie_pkg::mrie_faddr_t FILE_ADDR,
  input wire mrie_pkg::mrie_data_t FILE_WDATA,
  input wire logic GLOBAL_IRQ_ENABLE,
  input wire mrie_pkg::mrie_data_t IRQ_CTRL_SET,
  input wire logic INSTR_UNSUPPORTED
);
  import mrie_pkg::*;
  logic tk, cp, ld, rl, rt;
  assign tk = INSTR_VALID && INSTR_READY;
  assign cp = tk && (INSTR_WORD & OPC_COPY_MASK) == OPC_COPY_MATCH;
  assign ld = tk && (INSTR_WORD & OPC_LOAD_MASK) == OPC_LOAD_MATCH;
  assign rl = tk && (INSTR_WORD & OPC_RETLIT_MASK) == OPC_RETLIT_MATCH;
  assign rt = rl || (tk && (INSTR_WORD == 14'h0008 || INSTR_WORD == 14'h0009));
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);
  copy_write_a:
  assert property (cp |=> FILE_WE && FILE_ADDR == $past(INSTR_WORD[6:0])
    && FILE_WDATA == $past(ACC) && ACC == $past(ACC)) else $error("copy write wrong");
  load_acc_a:
  assert property (ld |=> ACC == $past(INSTR_WORD[7:0]) && !FILE_WE) else $error("load wrong");
  single_step_a:
  assert property (cp || ld |=> INSTR_READY && PC == $past(PC) + 13'h1) else $error("step wrong");
  idle_only_a:
  assert property (tk && INSTR_WORD == 14'h0000 |=> PC == $past(PC) + 13'h1 && $stable(ACC)
    && !FILE_WE) else $error("idle changed state");
  irq_enable_a:
  assert property (tk && INSTR_WORD == 14'h0009 |=> GLOBAL_IRQ_ENABLE
    && IRQ_CTRL_SET == 8'h80 ##1 IRQ_CTRL_SET == 8'h00) else $error("enable not set");
  ret_two_cyc_a:
  assert property (rt |=> !INSTR_READY ##1 INSTR_READY) else $error("return length wrong");
  retlit_acc_a:
  assert property (rl |=> ACC == $past(INSTR_WORD[7:0])) else $error("return literal wrong");
  stack_pop_a:
  assert property (STACK_PUSH && !tk ##1 rt && !STACK_PUSH
    |=> PC == $past(STACK_PUSH_ADDR, 2)) else $error("pop address wrong");
endmodule // mrie_exec_props
bind mrie_exec mrie_exec_props props_i (
  .CLK_SYS(CLK_SYS),
  .ARST_N(ARST_N),
  .INSTR_VALID(INSTR_VALID),
  .INSTR_WORD(INSTR_WORD),
  .INSTR_READY(INSTR_READY),
  .STACK_PUSH(STACK_PUSH),
  .STACK_PUSH_ADDR(STACK_PUSH_ADDR),
  .GIE_CLEAR(GIE_CLEAR),
  .PC(PC),
  .ACC(ACC),
  .FILE_WE(FILE_WE),
  .FILE_ADDR(FILE_ADDR),
  .FILE_WDATA(FILE_WDATA),
  .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE),
  .IRQ_CTRL_SET(IRQ_CTRL_SET),
  .INSTR_UNSUPPORTED(INSTR_UNSUPPORTED)
);
`default_nettype wire

//--- dv/mrie_exec_tb.sv
`timescale 1ns/1ps
`default_nettype none
module mrie_exec_tb;
  import mrie_pkg::*;
  logic clk, rst_n, vld, rdy, push, gclr, we, global_irq_enable, uns;
  mrie_instr_t word;
  mrie_pc_t paddr, pc, xpc;
  mrie_data_t acc, wd, ctl;
  mrie_faddr_t fa;
  int error_cnt, check_count;
  int cyc = 0;
  mrie_exec uut (.CLK_SYS(clk), .ARST_N(rst_n), .INSTR_VALID(vld), .INSTR_WORD(word),
    .INSTR_READY(rdy), .STACK_PUSH(push), .STACK_PUSH_ADDR(paddr), .GIE_CLEAR(gclr),
    .PC(pc), .ACC(acc), .FILE_WE(we), .FILE_ADDR(fa), .FILE_WDATA(wd),
    .GLOBAL_IRQ_ENABLE(global_irq_enable), .IRQ_CTRL_SET(ctl), .INSTR_UNSUPPORTED(uns));
  mrie_fetch_model fd (.clk(clk), .ready(rdy), .valid(vld), .word(word));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  task automatic run(input mrie_instr_t w);
    fd.issue(w);
    xpc = xpc + 13'h1;
  endtask
  task automatic t_load_idle();
    run(14'h33a5);
    check(acc, 8'ha5);
    check(pc, xpc);
    run(14'h0000);
    check(pc, xpc);
    check(acc, 8'ha5);
    check(we, 1'b0);
    check(uns, 1'b0);
    fd.rel();
    step();
    $display("load and idle test done");
  endtask
  task automatic t_copy();
    run(14'h00ff);
    check(we, 1'b1);
    check(fa, 7'h7f);
    check(wd, 8'ha5);
    check(rdy, 1'b1);
    run(14'h0080);
    check(fa, 7'h00);
    check(pc, xpc);
    fd.rel();
    step();
    check(we, 1'b0);
    check(acc, 8'ha5);
    $display("copy test done");
  endtask
  task automatic t_unsup();
    run(14'h0100);
    check(uns, 1'b1);
    check(pc, xpc);
    check(acc, 8'ha5);
    check(we, 1'b0);
    fd.rel();
    step();
    check(uns, 1'b0);
    $display("unsupported word test done");
  endtask
  task automatic t_returns();
    push = 1'b1;
    paddr = 13'h0123;
    step();
    paddr = 13'h1abc;
    step();
    push = 1'b0;
    gclr = 1'b1;
    fd.issue(14'h0009);
    gclr = 1'b0;
    check(pc, 13'h1abc);
    check(global_irq_enable, 1'b1);
    check(ctl, 8'h80);
    check(rdy, 1'b0);
    fd.issue(14'h37c3);
    check(pc, 13'h0123);
    check(acc, 8'hc3);
    check(rdy, 1'b0);
    check(ctl, 8'h00);
    check(global_irq_enable, 1'b1);
    fd.rel();
    push = 1'b1;
    paddr = 13'h0abc;
    step();
    push = 1'b0;
    fd.issue(14'h0008);
    check(pc, 13'h0abc);
    check(rdy, 1'b0);
    fd.rel();
    gclr = 1'b1;
    step();
    gclr = 1'b0;
    check(rdy, 1'b1);
    check(global_irq_enable, 1'b0);
    $display("return test done");
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Whole run needs about 32 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 400) begin
      error_cnt++;
      test_done();
    end
  end
  initial begin
    rst_n = 1'b0;
    push = 1'b0;
    paddr = 13'h0000;
    gclr = 1'b0;
    xpc = 13'h0000;
    error_cnt = 0;
    check_count = 0;
    repeat (16) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_load_idle();
    t_copy();
    t_unsup();
    t_returns();
    test_done();
  end
endmodule // mrie_exec_tb
`default_nettype wire

//--- dv/mrie_fetch_model.sv
`timescale 1ns/1ps
`default_nettype none
module mrie_fetch_model (
  input wire logic clk,
  input wire logic ready,
  output logic valid,
  output mrie_pkg::mrie_instr_t word
);
  import mrie_pkg::*;
  initial begin
    valid = 1'b0;
    word = 14'h0000;
  end
  // Word held until taken; wait bounded, a return stalls one cycle only
  task automatic issue(input mrie_instr_t w);
    int n;
    valid = 1'b1;
    word = w;
    n = 0;
    while (!ready && n < 4) begin
      @(posedge clk);
      #1;
      n++;
    end
    @(posedge clk);
    #1;
  endtask
  // Released bus shows the inverse, never a stale copy
  task automatic rel();
    valid = 1'b0;
    word = ~word;
  endtask
endmodule // mrie_fetch_model
`default_nettype wire

//--- logic/mrie_exec.sv
// Behaviour
// [RL1] Copy accumulator into file register chosen by 7-bit operand; one cycle, flags kept.
// [RL2] Load 8-bit literal into accumulator; one cycle, no flag altered.
// [RL3] Don't-care bits of literal instruction words count as zero.
// [RL4] Return from interrupt pops stack and loads popped top into program counter.
// [RL5] Return from interrupt sets global interrupt enable, bit 7 of control register.
// [RL6] Return from interrupt: one word, two cycles, flags unchanged.
// [RL7] Return with literal loads its 8-bit literal into accumulator.
// [RL8] Return with literal loads program counter from stack top.
// [RL9] Return with literal: one word, two cycles, flags unchanged.
// [RL10] Plain return pops stack into program counter; two cycles, flags unchanged.
// [RL11] Idle instruction: one cycle, only program counter advances.
// [RL12] Every pop moves stack pointer back one entry; a pop with a same-cycle push leaves it in place.
`timescale 1ns/1ps
`default_nettype none
module mrie_exec (
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  input wire logic INSTR_VALID,
  input wire mrie_pkg::mrie_instr_t INSTR_WORD,
  output logic INSTR_READY,
  input wire logic STACK_PUSH,
  input wire mrie_pkg::mrie_pc_t STACK_PUSH_ADDR,
  input wire logic GIE_CLEAR,
  output mrie_pkg::mrie_pc_t PC,
  output mrie_pkg::mrie_data_t ACC,
  output logic FILE_WE,
  output mrie_pkg::mrie_faddr_t FILE_ADDR,
  output mrie_pkg::mrie_data_t FILE_WDATA,
  output logic GLOBAL_IRQ_ENABLE,
  output mrie_pkg::mrie_data_t IRQ_CTRL_SET,
  output logic INSTR_UNSUPPORTED
);
  import mrie_pkg::*;

  function automatic logic op_is(input mrie_instr_t w, input mrie_instr_t mask,
                                 input mrie_instr_t match);
    op_is = ((w & mask) == match);
  endfunction

  // Pushes come from outside: call and interrupt entry live elsewhere
  mrie_stack_if stk ();

  mrie_stack u_stack (
    .clk (CLK_SYS),
    .arst_n (ARST_N),
    .stk (stk)
  );

  mrie_state_t state_r;
  mrie_state_t state_nxt;
  mrie_pc_t pc_r;
  mrie_pc_t pc_nxt;
  mrie_data_t acc_r;
  mrie_data_t acc_nxt;
  logic fwe_r;
  logic fwe_nxt;
  mrie_faddr_t faddr_r;
  mrie_faddr_t faddr_nxt;
  mrie_data_t fdata_r;
  mrie_data_t fdata_nxt;
  logic gie_r;
  logic gie_nxt;
  mrie_data_t ctrl_set_r;
  mrie_data_t ctrl_set_nxt;
  logic unsup_r;
  logic unsup_nxt;
  logic take;
  mrie_instr_t word;
  mrie_op_t op;
  mrie_data_t lit;

  // Second cycle of a return is a dead slot while fetch refills
  assign INSTR_READY = (state_r == MRIE_ST_EXEC);
  assign take = INSTR_VALID && INSTR_READY;

  always_comb begin
    word = INSTR_WORD;
    if (op_is(INSTR_WORD, OPC_LOAD_MASK, OPC_LOAD_MATCH) ||
        op_is(INSTR_WORD, OPC_RETLIT_MASK, OPC_RETLIT_MATCH)) begin
      word = INSTR_WORD & ~LIT_DONT_CARE; // RL3
    end
    lit = word[LIT_LSB +: DATA_W];
    if (op_is(word, OPC_FULL_MASK, OPC_RETIRQ_MATCH)) begin
      op = MRIE_OP_RETIRQ;
    end else if (op_is(word, OPC_FULL_MASK, OPC_RETURN_MATCH)) begin
      op = MRIE_OP_RETURN;
    end else if (op_is(word, OPC_COPY_MASK, OPC_COPY_MATCH)) begin
      op = MRIE_OP_COPY;
    end else if (op_is(word, OPC_IDLE_MASK, OPC_IDLE_MATCH)) begin
      op = MRIE_OP_IDLE;
    end else if (op_is(word, OPC_LOAD_MASK, OPC_LOAD_MATCH)) begin
      op = MRIE_OP_LOAD;
    end else if (op_is(word, OPC_RETLIT_MASK, OPC_RETLIT_MATCH)) begin
      op = MRIE_OP_RETLIT;
    end else begin
      op = MRIE_OP_OTHER;
    end
    if (!take) begin
      op = MRIE_OP_NONE;
    end
  end

  // Pops happen on the take edge so the top is read before it moves
  always_comb begin
    stk.pop = (op == MRIE_OP_RETIRQ) || (op == MRIE_OP_RETLIT) ||
              (op == MRIE_OP_RETURN); // RL4 RL10 RL12
    stk.push = STACK_PUSH;
    stk.push_addr = STACK_PUSH_ADDR;
  end

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      MRIE_ST_EXEC: begin
        if (stk.pop) begin
          state_nxt = MRIE_ST_FLUSH; // RL6 RL9 RL10
        end
      end
      MRIE_ST_FLUSH: begin
        state_nxt = MRIE_ST_EXEC;
      end
      default: begin
        state_nxt = MRIE_ST_EXEC;
      end
    endcase
  end

  // No status flags live here: none of these six touch them
  always_comb begin
    pc_nxt = pc_r;
    acc_nxt = acc_r;
    fwe_nxt = 1'b0;
    faddr_nxt = faddr_r;
    fdata_nxt = fdata_r;
    gie_nxt = gie_r;
    ctrl_set_nxt = CTRL_NONE;
    unsup_nxt = 1'b0;
    // Clear first so a same-cycle return from interrupt sets it again
    if (GIE_CLEAR) begin
      gie_nxt = 1'b0;
    end
    unique case (op)
      MRIE_OP_COPY: begin
        fwe_nxt = 1'b1; // RL1
        faddr_nxt = word[FADDR_LSB +: FADDR_W]; // RL1
        fdata_nxt = acc_r; // RL1
        pc_nxt = mrie_pc_t'(pc_r + PC_STEP);
      end
      MRIE_OP_LOAD: begin
        acc_nxt = lit; // RL2
        pc_nxt = mrie_pc_t'(pc_r + PC_STEP);
      end
      MRIE_OP_IDLE: begin
        pc_nxt = mrie_pc_t'(pc_r + PC_STEP); // RL11
      end
      MRIE_OP_RETIRQ: begin
        pc_nxt = stk.top; // RL4
        gie_nxt = 1'b1; // RL5
        ctrl_set_nxt[GIE_BIT] = 1'b1; // RL5
      end
      MRIE_OP_RETLIT: begin
        acc_nxt = lit; // RL7
        pc_nxt = stk.top; // RL8
      end
      MRIE_OP_RETURN: begin
        pc_nxt = stk.top; // RL10
      end
      // Unknown words still advance so fetch never stalls on them
      MRIE_OP_OTHER: begin
        unsup_nxt = 1'b1;
        pc_nxt = mrie_pc_t'(pc_r + PC_STEP);
      end
      MRIE_OP_NONE: begin
        pc_nxt = pc_r;
      end
      default: begin
        pc_nxt = pc_r;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      state_r <= MRIE_ST_EXEC;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      pc_r <= PC_RST;
      acc_r <= ACC_RST;
      fwe_r <= 1'b0;
      faddr_r <= '0;
      fdata_r <= ACC_RST;
      gie_r <= 1'b0;
      ctrl_set_r <= CTRL_NONE;
      unsup_r <= 1'b0;
    end else begin
      pc_r <= pc_nxt;
      acc_r <= acc_nxt;
      fwe_r <= fwe_nxt;
      faddr_r <= faddr_nxt;
      fdata_r <= fdata_nxt;
      gie_r <= gie_nxt;
      ctrl_set_r <= ctrl_set_nxt;
      unsup_r <= unsup_nxt;
    end
  end

  assign PC = pc_r;
  assign ACC = acc_r;
  assign FILE_WE = fwe_r;
  assign FILE_ADDR = faddr_r;
  assign FILE_WDATA = fdata_r;
  assign GLOBAL_IRQ_ENABLE = gie_r;
  assign IRQ_CTRL_SET = ctrl_set_r;
  assign INSTR_UNSUPPORTED = unsup_r;
endmodule // mrie_exec
`default_nettype wire

//--- logic/mrie_pkg.sv
`default_nettype none
package mrie_pkg;
  localparam int INSTR_W = 14;
  localparam int PC_W = 13;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int STACK_DEPTH = 8;
  localparam int SP_W = 3;

  typedef logic [INSTR_W-1:0] mrie_instr_t;
  typedef logic [PC_W-1:0] mrie_pc_t;
  typedef logic [DATA_W-1:0] mrie_data_t;
  typedef logic [FADDR_W-1:0] mrie_faddr_t;
  typedef logic [SP_W-1:0] mrie_sp_t;

  // Opcode patterns: a word matches when (word & mask) == match
  localparam mrie_instr_t OPC_COPY_MASK = 14'h3f80;
  localparam mrie_instr_t OPC_COPY_MATCH = 14'h0080;
  localparam mrie_instr_t OPC_LOAD_MASK = 14'h3c00;
  localparam mrie_instr_t OPC_LOAD_MATCH = 14'h3000;
  localparam mrie_instr_t OPC_RETLIT_MASK = 14'h3c00;
  localparam mrie_instr_t OPC_RETLIT_MATCH = 14'h3400;
  localparam mrie_instr_t OPC_IDLE_MASK = 14'h3f9f;
  localparam mrie_instr_t OPC_IDLE_MATCH = 14'h0000;
  localparam mrie_instr_t OPC_FULL_MASK = 14'h3fff;
  localparam mrie_instr_t OPC_RETIRQ_MATCH = 14'h0009;
  localparam mrie_instr_t OPC_RETURN_MATCH = 14'h0008;
  // Don't-care bits of the literal forms, forced to zero
  localparam mrie_instr_t LIT_DONT_CARE = 14'h0300;

  localparam int FADDR_LSB = 0;
  localparam int LIT_LSB = 0;
  localparam int GIE_BIT = 7;

  localparam mrie_data_t ACC_RST = 8'h00;
  localparam mrie_pc_t PC_RST = 13'h0000;
  localparam mrie_pc_t PC_STEP = 13'h0001;
  localparam mrie_sp_t SP_RST = 3'h0;
  localparam mrie_sp_t SP_STEP = 3'h1;
  localparam mrie_data_t CTRL_NONE = 8'h00;

  typedef enum logic [1:0] {
    MRIE_ST_EXEC = 2'b01,
    MRIE_ST_FLUSH = 2'b10
  } mrie_state_t;

  typedef enum logic [2:0] {
    MRIE_OP_NONE,
    MRIE_OP_COPY,
    MRIE_OP_LOAD,
    MRIE_OP_IDLE,
    MRIE_OP_RETIRQ,
    MRIE_OP_RETLIT,
    MRIE_OP_RETURN,
    MRIE_OP_OTHER
  } mrie_op_t;
endpackage
`default_nettype wire

//--- logic/mrie_stack.sv
`timescale 1ns/1ps
`default_nettype none
module mrie_stack (
  input wire logic clk,
  input wire logic arst_n,
  mrie_stack_if.store stk
);
  import mrie_pkg::*;

  mrie_sp_t sp_r;
  mrie_sp_t sp_nxt;
  mrie_sp_t wr_idx;
  mrie_pc_t mem_r [STACK_DEPTH];
  mrie_pc_t mem_nxt [STACK_DEPTH];

  // Circular store: depth overflow wraps silently
  always_comb begin
    sp_nxt = sp_r;
    wr_idx = stk.pop ? mrie_sp_t'(sp_r - SP_STEP) : sp_r;
    if (stk.push && !stk.pop) begin
      sp_nxt = mrie_sp_t'(sp_r + SP_STEP);
    end else if (stk.pop && !stk.push) begin
      sp_nxt = mrie_sp_t'(sp_r - SP_STEP); // RL12
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sp_r <= SP_RST;
    end else begin
      sp_r <= sp_nxt;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < STACK_DEPTH; gi++) begin : g_entry
      always_comb begin
        mem_nxt[gi] = mem_r[gi];
        if (stk.push && (wr_idx == mrie_sp_t'(gi))) begin
          mem_nxt[gi] = stk.push_addr;
        end
      end

      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          mem_r[gi] <= PC_RST;
        end else begin
          mem_r[gi] <= mem_nxt[gi];
        end
      end
    end
  endgenerate

  assign stk.top = mem_r[mrie_sp_t'(sp_r - SP_STEP)];
endmodule // mrie_stack
`default_nettype wire

//--- logic/mrie_stack_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mrie_stack_if;
  import mrie_pkg::*;
  logic push;
  logic pop;
  mrie_pc_t push_addr;
  mrie_pc_t top;
  modport ctrl (output push, output pop, output push_addr, input top);
  modport store (input push, input pop, input push_addr, output top);
endinterface
`default_nettype wire
